//--- status_pkg.sv
// Register map, field positions and reset values of the status reporting block
// How it works
// - Master summary set by any enabled status bit
// - Master summary drives service request interrupt
// - Enable bit 6 never feeds master summary
// - Service enable mask reads back programmed value
// - Event summary set by enabled latched events
// - Event bit 6 excluded from event summary
// - Event enable mask stored and read back exactly
// - Event bits latch until read or clear
// - Power-on leaves only event bit 7 set
// - Event read returns value, then releases bits
// - Clear zeroes events and both enable masks
// - Clear zeroes operation event and enable
// - Clear zeroes questionable event and enable
// - Summary rise and fall raise interrupts
// - Summary follows live status, not latched
// - Status bits 7,5,4 assigned, 3..0 zero
// - Fixed event bit layout, bits 6,1 zero
`default_nettype none
package status_pkg;
  // ****************
  // Register offsets
  // ****************
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_EVT = 12'h004;
  localparam logic [11:0] OFS_EVT_EN = 12'h008;
  localparam logic [11:0] OFS_SRQ_EN = 12'h00c;
  localparam logic [11:0] OFS_STB = 12'h010;
  localparam logic [11:0] OFS_OPER_EVT = 12'h014;
  localparam logic [11:0] OFS_OPER_EN = 12'h018;
  localparam logic [11:0] OFS_QUES_EVT = 12'h01c;
  localparam logic [11:0] OFS_QUES_EN = 12'h020;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h024;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h028;
  // ****************
  // Field positions
  // ****************
  localparam int CMD_CLEAR = 0;
  localparam int CMD_OPC = 1;
  localparam int EVT_PON = 7;
  localparam int EVT_CME = 5;
  localparam int EVT_EXE = 4;
  localparam int EVT_DDE = 3;
  localparam int EVT_QYE = 2;
  localparam int EVT_OPC = 0;
  localparam int STB_OPER = 7;
  localparam int STB_MSS = 6;
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;
  localparam int IRQ_RISE = 0;
  localparam int IRQ_FALL = 1;
  // ****************
  // Values and masks
  // ****************
  localparam logic [7:0] EVT_RESET = 8'h80;
  localparam logic [7:0] EVT_SUM_MASK = 8'hbf;
  localparam logic [7:0] SRQ_SUM_MASK = 8'hbf;
  localparam logic [1:0] IRQ_RESET = 2'h0;
endpackage : status_pkg
`default_nettype wire

//--- summary_if.sv
// Carrier between the register logic and the summary logic
`timescale 1ns/100ps
`default_nettype none
interface summary_if;
  logic [7:0] evt;
  logic [7:0] evt_en;
  logic [7:0] srq_en;
  logic oper_any;
  logic msg_avail;
  logic [7:0] stb;
  logic mss;
  modport regs (output evt, output evt_en, output srq_en, output oper_any, output msg_avail, input stb, input mss);
  modport calc (input evt, input evt_en, input srq_en, input oper_any, input msg_avail, output stb, output mss);
endinterface : summary_if
`default_nettype wire

//--- status_summary.sv
// Combinational status byte and master summary
`timescale 1ns/100ps
`default_nettype none
module status_summary (
  summary_if.calc bus
);
  logic esb;
  logic [7:0] live;

  always_comb begin
    esb = |(bus.evt & bus.evt_en & status_pkg::EVT_SUM_MASK);
    live = 8'h00;
    live[status_pkg::STB_OPER] = bus.oper_any;
    live[status_pkg::STB_ESB] = esb;
    live[status_pkg::STB_MAV] = bus.msg_avail;
    bus.mss = |(live & bus.srq_en & status_pkg::SRQ_SUM_MASK);
    bus.stb = live;
    bus.stb[status_pkg::STB_MSS] = bus.mss;
  end
endmodule : status_summary
`default_nettype wire

//--- status_reporting.sv
// Status reporting registers with APB access and service request interrupt
`timescale 1ns/100ps
`default_nettype none
module status_reporting #(
  parameter int OPER_W = 16,
  parameter int QUES_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_err,
  input wire logic exec_err,
  input wire logic dev_err,
  input wire logic query_err,
  input wire logic msg_avail,
  input wire logic [OPER_W-1:0] oper_cond,
  input wire logic [QUES_W-1:0] ques_cond,
  output logic [7:0] status_byte,
  output logic service_request,
  output logic irq
);
  // ****************
  // State
  // ****************
  logic [7:0] evt;
  logic [7:0] next_evt;
  logic [7:0] evt_en;
  logic [7:0] next_evt_en;
  logic [7:0] srq_en;
  logic [7:0] next_srq_en;
  logic [OPER_W-1:0] oper_evt;
  logic [OPER_W-1:0] next_oper_evt;
  logic [OPER_W-1:0] oper_en;
  logic [OPER_W-1:0] next_oper_en;
  logic [QUES_W-1:0] ques_evt;
  logic [QUES_W-1:0] next_ques_evt;
  logic [QUES_W-1:0] ques_en;
  logic [QUES_W-1:0] next_ques_en;
  logic [1:0] irq_stat;
  logic [1:0] next_irq_stat;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_mask;
  logic [31:0] next_prdata;
  logic [7:0] next_status_byte;
  logic mss_q;
  logic next_mss_q;
  logic setup_rd;
  logic acc;
  logic wr;
  logic rd;
  logic cls;
  logic opc;
  logic mapped;
  logic mss_rise;
  logic mss_fall;
  logic wr_cmd;
  logic wr_evt_en;
  logic wr_srq_en;
  logic wr_oper_en;
  logic wr_ques_en;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic rd_evt;
  logic [7:0] evt_set;
  logic [7:0] evt_rd_clr;

  summary_if sif ();

  status_summary u_summary (
    .bus(sif.calc)
  );

  assign sif.evt = evt;
  assign sif.evt_en = evt_en;
  assign sif.srq_en = srq_en;
  assign sif.oper_any = |oper_evt;
  assign sif.msg_avail = msg_avail;

  // ****************
  // Bus decode
  // ****************
  always_comb begin
    case (paddr)
      status_pkg::OFS_CMD,
      status_pkg::OFS_EVT,
      status_pkg::OFS_EVT_EN,
      status_pkg::OFS_SRQ_EN,
      status_pkg::OFS_STB,
      status_pkg::OFS_OPER_EVT,
      status_pkg::OFS_OPER_EN,
      status_pkg::OFS_QUES_EVT,
      status_pkg::OFS_QUES_EN,
      status_pkg::OFS_IRQ_STAT,
      status_pkg::OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign acc = psel & penable;
  assign wr = acc & pwrite & mapped;
  assign rd = acc & ~pwrite & mapped;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // ****************
  // Register strobes
  // ****************
  assign wr_cmd = wr && paddr == status_pkg::OFS_CMD;
  assign wr_evt_en = wr && paddr == status_pkg::OFS_EVT_EN;
  assign wr_srq_en = wr && paddr == status_pkg::OFS_SRQ_EN;
  assign wr_oper_en = wr && paddr == status_pkg::OFS_OPER_EN;
  assign wr_ques_en = wr && paddr == status_pkg::OFS_QUES_EN;
  assign wr_irq_stat = wr && paddr == status_pkg::OFS_IRQ_STAT;
  assign wr_irq_mask = wr && paddr == status_pkg::OFS_IRQ_MASK;
  assign rd_evt = rd && paddr == status_pkg::OFS_EVT;
  assign cls = wr_cmd & pwdata[status_pkg::CMD_CLEAR];
  assign opc = wr_cmd & pwdata[status_pkg::CMD_OPC];

  // ****************
  // Standard event register
  // ****************
  always_comb begin
    evt_set = 8'h00;
    evt_set[status_pkg::EVT_CME] = cmd_err;
    evt_set[status_pkg::EVT_EXE] = exec_err;
    evt_set[status_pkg::EVT_DDE] = dev_err;
    evt_set[status_pkg::EVT_QYE] = query_err;
    evt_set[status_pkg::EVT_OPC] = opc;
    // Only the bits handed out in the read are released, so a late set survives
    evt_rd_clr = 8'h00;
    if (rd_evt) begin
      evt_rd_clr = prdata[7:0];
    end
    next_evt = evt;
    if (cls) begin
      next_evt = 8'h00;
    end
    next_evt = (next_evt & ~evt_rd_clr) | evt_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt <= status_pkg::EVT_RESET;
    end else begin
      evt <= next_evt;
    end
  end

  // ****************
  // Enable masks
  // ****************
  always_comb begin
    next_evt_en = evt_en;
    next_srq_en = srq_en;
    if (wr_evt_en) begin
      next_evt_en = pwdata[7:0];
    end
    if (wr_srq_en) begin
      next_srq_en = pwdata[7:0];
    end
    if (cls) begin
      next_evt_en = 8'h00;
      next_srq_en = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_en <= 8'h00;
      srq_en <= 8'h00;
    end else begin
      evt_en <= next_evt_en;
      srq_en <= next_srq_en;
    end
  end

  // ****************
  // Operation and questionable registers
  // ****************
  always_comb begin
    next_oper_evt = oper_evt | oper_cond;
    next_oper_en = oper_en;
    next_ques_evt = ques_evt | ques_cond;
    next_ques_en = ques_en;
    if (wr_oper_en) begin
      next_oper_en = pwdata[OPER_W-1:0];
    end
    if (wr_ques_en) begin
      next_ques_en = pwdata[QUES_W-1:0];
    end
    if (cls) begin
      // A condition held high in the clear cycle sets its bit again
      next_oper_evt = oper_cond;
      next_oper_en = '0;
      next_ques_evt = ques_cond;
      next_ques_en = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oper_evt <= '0;
      oper_en <= '0;
      ques_evt <= '0;
      ques_en <= '0;
    end else begin
      oper_evt <= next_oper_evt;
      oper_en <= next_oper_en;
      ques_evt <= next_ques_evt;
      ques_en <= next_ques_en;
    end
  end

  // ****************
  // Interrupt status
  // ****************
  assign mss_rise = sif.mss & ~mss_q;
  assign mss_fall = ~sif.mss & mss_q;
  assign irq = |(irq_stat & irq_mask);

  always_comb begin
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_mss_q = sif.mss;
    if (wr_irq_mask) begin
      next_irq_mask = pwdata[1:0];
    end
    if (wr_irq_stat) begin
      next_irq_stat = irq_stat & ~pwdata[1:0];
    end
    // An edge in the clearing cycle wins over the clear
    next_irq_stat[status_pkg::IRQ_RISE] = next_irq_stat[status_pkg::IRQ_RISE] | mss_rise;
    next_irq_stat[status_pkg::IRQ_FALL] = next_irq_stat[status_pkg::IRQ_FALL] | mss_fall;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= status_pkg::IRQ_RESET;
      irq_mask <= status_pkg::IRQ_RESET;
      mss_q <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      mss_q <= next_mss_q;
    end
  end

  // ****************
  // Read data
  // ****************
  always_comb begin
    next_prdata = prdata;
    if (setup_rd) begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        status_pkg::OFS_EVT: next_prdata[7:0] = evt;
        status_pkg::OFS_EVT_EN: next_prdata[7:0] = evt_en;
        status_pkg::OFS_SRQ_EN: next_prdata[7:0] = srq_en;
        status_pkg::OFS_STB: next_prdata[7:0] = sif.stb;
        status_pkg::OFS_OPER_EVT: next_prdata[OPER_W-1:0] = oper_evt;
        status_pkg::OFS_OPER_EN: next_prdata[OPER_W-1:0] = oper_en;
        status_pkg::OFS_QUES_EVT: next_prdata[QUES_W-1:0] = ques_evt;
        status_pkg::OFS_QUES_EN: next_prdata[QUES_W-1:0] = ques_en;
        status_pkg::OFS_IRQ_STAT: next_prdata[1:0] = irq_stat;
        status_pkg::OFS_IRQ_MASK: next_prdata[1:0] = irq_mask;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ****************
  // Status byte
  // ****************
  always_comb begin
    next_status_byte = sif.stb;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_byte <= 8'h00;
    end else begin
      status_byte <= next_status_byte;
    end
  end

  assign service_request = mss_q;
endmodule : status_reporting
`default_nettype wire

//--- status_reporting_checker.sv
// Port assertions for the status reporting block
`timescale 1ns/100ps
`default_nettype none
module status_reporting_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic msg_avail,
  input wire logic [7:0] status_byte,
  input wire logic service_request,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_setup;
  assign rd_setup = psel && !penable && !pwrite;
  a_low_nibble_zero: assert property (status_byte[3:0] == 4'h0)
    else $error("status byte low bits set");
  a_msg_follows: assert property ($past(presetn) |-> status_byte[4] == $past(msg_avail))
    else $error("message bit does not follow input");
  a_srv_is_mss: assert property (service_request == status_byte[6])
    else $error("service request differs from summary bit");
  a_mss_needs_src: assert property ({status_byte[7], status_byte[5:4]} == 3'h0 |-> !service_request)
    else $error("summary set with no status source");
  a_ready_tied: assert property (pready)
    else $error("ready low");
  a_good_addr_ok: assert property (psel && penable && paddr <= status_pkg::OFS_IRQ_MASK && paddr[1:0] == 2'h0
    |-> !pslverr)
    else $error("error on mapped address");
  a_bad_addr_err: assert property (psel && penable && paddr > status_pkg::OFS_IRQ_MASK |-> pslverr)
    else $error("unmapped access not refused");
  a_bad_rd_zero: assert property (psel && penable && !pwrite && paddr > status_pkg::OFS_IRQ_MASK
    |-> prdata == 32'h0000_0000)
    else $error("unmapped read returns data");
  a_evt_gaps: assert property (rd_setup && paddr == status_pkg::OFS_EVT |=> prdata[31:8] == 24'h00_0000
    && !prdata[6] && !prdata[1])
    else $error("event read shows unused bits");
  a_mask_width: assert property (rd_setup && paddr == status_pkg::OFS_SRQ_EN |=> prdata[31:8] == 24'h00_0000)
    else $error("request mask wider than a byte");
  cover property ($rose(service_request));
  cover property ($fell(service_request));
  cover property (irq);
  cover property (pslverr);
endmodule : status_reporting_checker
bind status_reporting status_reporting_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .msg_avail(msg_avail), .status_byte(status_byte), .service_request(service_request), .irq(irq));
`default_nettype wire

//--- host_model.sv
// Host controller model issuing register commands and queries
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic pclk,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0000_0000,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : host_model
`default_nettype wire

//--- status_reporting_bench.sv
// Self-checking bench for the status reporting block
`timescale 1ns/100ps
`default_nettype none
module status_reporting_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, service_request, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:0] errs = 4'h0;
  logic msg_avail = 1'b0;
  logic [15:0] oper_cond = 16'h0000;
  logic [15:0] ques_cond = 16'h0000;
  logic [7:0] status_byte;
  logic [31:0] lfsr = 32'h2ff1_f19c;
  int fails = 0;
  int total_checks = 0;
  int evt, ese, sre, stb, mss, msg, oper, prev;
  localparam logic [11:0] CLR[7] = '{status_pkg::OFS_EVT, status_pkg::OFS_EVT_EN, status_pkg::OFS_SRQ_EN,
    status_pkg::OFS_OPER_EVT, status_pkg::OFS_OPER_EN, status_pkg::OFS_QUES_EVT, status_pkg::OFS_QUES_EN};
  always #4 pclk = ~pclk;
  status_reporting DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_err(errs[3]),
    .exec_err(errs[2]), .dev_err(errs[1]), .query_err(errs[0]), .msg_avail(msg_avail), .oper_cond(oper_cond),
    .ques_cond(ques_cond), .status_byte(status_byte), .service_request(service_request), .irq(irq));
  host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready));
  function automatic logic [31:0] rnd();
    for (int k = 0; k < 32; k++) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0000_0000, rd);
    chk(n, e, rd);
  endtask : rdc
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic look();
    repeat (4) @(posedge pclk);
    stb = (oper ? 128 : 0) | ((evt & ese & 191) ? 32 : 0) | (msg ? 16 : 0);
    mss = (stb & sre & 191) ? 1 : 0;
    stb = stb | (mss * 64);
    chk("status byte", stb, {24'h00_0000, status_byte});
    chk("service request", mss, {31'h0, service_request});
  endtask : look
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  initial begin
    #100000;
    fails++;
    results();
  end
  initial begin
    {evt, ese, sre, msg, oper} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc("power-on events", status_pkg::OFS_EVT, 32'h0000_0080);
    rdc("events after read", status_pkg::OFS_EVT, 32'h0000_0000);
    rdc("unmapped read", 12'h02c, 32'h0000_0000);
    wr(status_pkg::OFS_IRQ_MASK, 32'h0000_0003);
    for (int i = 0; i < 16; i++) begin
      wr(status_pkg::OFS_IRQ_STAT, 32'h0000_0003);
      v = rnd();
      @(posedge pclk);
      errs <= v[3:0];
      oper_cond <= v[4] ? v[31:16] : 16'h0000;
      ques_cond <= v[15:0];
      msg_avail <= v[5];
      @(posedge pclk);
      errs <= 4'h0;
      oper_cond <= 16'h0000;
      ques_cond <= 16'h0000;
      evt = evt | (v[3:0] * 4);
      msg = v[5];
      oper = oper | (v[4] && v[31:16] != 16'h0000);
      if (v[6]) begin
        wr(status_pkg::OFS_CMD, 32'h0000_0002);
        evt = evt | 1;
      end
      ese = v[15:8];
      sre = v[23:16];
      wr(status_pkg::OFS_EVT_EN, ese);
      wr(status_pkg::OFS_SRQ_EN, sre);
      wr(status_pkg::OFS_OPER_EN, v);
      wr(status_pkg::OFS_QUES_EN, v);
      look();
      chk("irq rise", mss, {31'h0, irq});
      rdc("event mask", status_pkg::OFS_EVT_EN, ese);
      rdc("request mask", status_pkg::OFS_SRQ_EN, sre);
      rdc("events", status_pkg::OFS_EVT, evt);
      evt = 0;
      look();
      prev = mss;
      wr(status_pkg::OFS_IRQ_STAT, 32'h0000_0003);
      wr(status_pkg::OFS_CMD, 32'h0000_0001);
      {ese, sre, oper} = '0;
      look();
      chk("irq fall", prev, {31'h0, irq});
      foreach (CLR[k]) rdc("cleared", CLR[k], 32'h0000_0000);
    end
    results();
  end
endmodule : status_reporting_bench
`default_nettype wire
